// ---- fled_consts.vh ----
// fled_consts.vh: timing counts and state codes for the fieldbus led pattern generator
// assumes clk at 100 MHz; included by every design file of the block
`ifndef FLED_CONSTS_VH
`define FLED_CONSTS_VH

// clock period in ns
`define FLED_CLK_PERIOD_NS   10
// pattern phase lengths in ms
`define FLED_FLICKER_MS      50
`define FLED_FLASH_MS        200
`define FLED_PAUSE_MS        1000
// base tick: 50 ms in clock cycles, every phase is a whole number of ticks
`define FLED_TICK_CYCLES     ((`FLED_FLICKER_MS * 1000000) / `FLED_CLK_PERIOD_NS)
// phase lengths in ticks
`define FLED_FLASH_TICKS     (`FLED_FLASH_MS / `FLED_FLICKER_MS)
`define FLED_PAUSE_TICKS     (`FLED_PAUSE_MS / `FLED_FLICKER_MS)
// activity flicker hold after traffic stops, in ticks
`define FLED_ACT_HOLD_TICKS  2

// fieldbus state codes on al_state
`define FLED_ST_INIT         4'h1
`define FLED_ST_PREOP        4'h2
`define FLED_ST_BOOT         4'h3
`define FLED_ST_SAFEOP       4'h4
`define FLED_ST_OP           4'h8

// change/error flag value: booting error in init, autonomous state change in other states
`define FLED_CHANGE_ERR      8'h01

`endif

// ---- fled_led_mon.sv ----
// fled_led_mon.sv: behavioural indicator lamp, records run lengths
// assumes lit is sampled on the same clk as the generator
`timescale 1ns/10ps

module fled_led_mon (
    input  wire        clk,
    input  wire        lit,
    output reg  [15:0] on_len,
    output reg  [15:0] off_len,
    output reg  [7:0]  rises
);
    reg [15:0] run;
    reg        prev;

    initial begin
        {on_len, off_len, rises, run, prev} = 0;
    end

    // lamp lights with a high drive, length of the latest lit and dark run kept
    always @(posedge clk) begin
        if (lit !== prev) begin
            if (prev)
                on_len <= run;
            else
                off_len <= run;
            run <= 16'h0001;
            if (lit)
                rises <= rises + 8'h01;
        end else
            run <= run + 16'h0001;
        prev <= lit;
    end
endmodule

// ---- fled_link.v ----
// fled_link.v: one port's link/activity indicator
// assumes link_valid and activity synchronous to clk, tick a one-cycle pulse every 50 ms
`timescale 1ns/10ps
`include "fled_consts.vh"

module fled_link #(
    parameter HOLD_TICKS = `FLED_ACT_HOLD_TICKS
) (
    input  wire clk,
    input  wire reset_n,
    input  wire tick,
    input  wire flicker,
    input  wire link_valid,
    input  wire activity,
    output reg  led_q
);

    reg [3:0] hold_q;

    // stretch traffic so short bursts still show a flicker
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= 4'h0;
        end else if (!link_valid) begin
            hold_q <= 4'h0;
        end else if (activity) begin
            hold_q <= HOLD_TICKS[3:0];
        end else if (tick && hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end
    end

    // off without link, steady on when idle, flicker with traffic
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            led_q <= 1'b0;
        end else if (!link_valid) begin
            led_q <= 1'b0;
        end else if (hold_q != 4'h0 || activity) begin
            led_q <= flicker;
        end else begin
            led_q <= 1'b1;
        end
    end

endmodule

// ---- fled_top.v ----
// fled_top.v: fieldbus indicator pattern generator, link, state and error leds
// assumes all inputs synchronous to clk; leds are active high, off during reset
//
// Behaviour
// - link led: on when link idle, flicker with traffic, off without link
// - green state led steady on in operational
// - green blinks 200 ms on, 200 ms off in pre-operational
// - green single flash 200 ms on, 1000 ms off in safe-operational
// - green flickers 50/50 ms while booting, in bootstrap, or during download
// - green dark in init
// - red steady on after process-data-interface watchdog timeout
// - red blinks 200/200 ms on general configuration error
// - red flickers 50/50 ms on booting error: init with flag 0x01
// - red single flash on autonomous state change with flag 0x01
// - red double flash on application watchdog timeout
// - separate in and out link outputs, plus green/red state pair
`timescale 1ns/10ps
`include "fled_consts.vh"

module fled_top #(
    parameter TICK_CYCLES = `FLED_TICK_CYCLES
) (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       link_in_valid,
    input  wire       link_in_activity,
    input  wire       link_out_valid,
    input  wire       link_out_activity,
    input  wire [3:0] al_state,
    input  wire       al_state_valid,
    input  wire       fw_download,
    input  wire [7:0] al_change_flag,
    input  wire       pdi_wdog_timeout,
    input  wire       config_error,
    input  wire       app_wdog_timeout,
    output wire       port_in_link_indicator,
    output wire       port_out_link_indicator,
    output reg        status_green_q,
    output reg        error_red_q,
    output reg        bicolor_pos_q,
    output reg        bicolor_neg_q
);

    // pattern selector codes, one-hot
    localparam [4:0] PAT_OFF     = 5'h01;
    localparam [4:0] PAT_ON      = 5'h02;
    localparam [4:0] PAT_BLINK   = 5'h04;
    localparam [4:0] PAT_SINGLE  = 5'h08;
    localparam [4:0] PAT_DOUBLE  = 5'h10;
    localparam       FLICK_SEL   = 1'b1;

    localparam       FLASH_N = `FLED_FLASH_TICKS;
    localparam       PAUSE_N = `FLED_PAUSE_TICKS;
    // phase lengths cut to the counter width on purpose
    localparam [4:0] FLASH_T = FLASH_N[4:0];
    localparam [4:0] PAUSE_T = PAUSE_N[4:0];
    // single flash frame: on + pause; double: on,off,on + pause
    localparam [4:0] SINGLE_LEN = FLASH_T + PAUSE_T;
    localparam [5:0] DOUBLE_LEN = {1'b0, FLASH_T} + {1'b0, FLASH_T} + {1'b0, FLASH_T} + {1'b0, PAUSE_T};

    reg [22:0] tdiv_q;
    reg        tick_q;
    reg        flick_q;
    reg [1:0]  blink_cnt_q;
    reg        blink_q;
    reg [4:0]  single_cnt_q;
    reg [5:0]  double_cnt_q;
    reg [5:0]  frame_q;
    reg        single_q;
    reg        double_q;

    // shared 50 ms timebase
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tdiv_q <= 23'h000000;
            tick_q <= 1'b0;
        end else if (tdiv_q == TICK_CYCLES[22:0] - 23'h000001) begin
            tdiv_q <= 23'h000000;
            tick_q <= 1'b1;
        end else begin
            tdiv_q <= tdiv_q + 23'h000001;
            tick_q <= 1'b0;
        end
    end

    // free-running pattern phases, all stepped by the same tick
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flick_q      <= 1'b0;
            blink_cnt_q  <= 2'h0;
            blink_q      <= 1'b0;
            single_cnt_q <= 5'h00;
            double_cnt_q <= 6'h00;
        end else if (tick_q) begin
            flick_q <= ~flick_q;
            if (blink_cnt_q == FLASH_T[1:0] - 2'h1) begin
                blink_cnt_q <= 2'h0;
                blink_q     <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 2'h1;
            end
            if (single_cnt_q == SINGLE_LEN - 5'h01) begin
                single_cnt_q <= 5'h00;
            end else begin
                single_cnt_q <= single_cnt_q + 5'h01;
            end
            if (double_cnt_q == DOUBLE_LEN - 6'h01) begin
                double_cnt_q <= 6'h00;
            end else begin
                double_cnt_q <= double_cnt_q + 6'h01;
            end
        end
    end

    // decode lit windows of the flash frames
    always @* begin
        frame_q  = double_cnt_q;
        single_q = (single_cnt_q < FLASH_T);
        double_q = (frame_q < {1'b0, FLASH_T}) ||
                   (frame_q >= {1'b0, FLASH_T} + {1'b0, FLASH_T} &&
                    frame_q <  {1'b0, FLASH_T} + {1'b0, FLASH_T} + {1'b0, FLASH_T});
    end

    reg [4:0] green_sel;
    reg       green_flick;
    reg [4:0] red_sel;
    reg       red_flick;

    // green pattern from the fieldbus state
    always @* begin
        green_sel   = PAT_OFF;
        green_flick = 1'b0;
        if (fw_download || !al_state_valid || al_state == `FLED_ST_BOOT) begin
            green_flick = FLICK_SEL;
        end else begin
            case (al_state)
                `FLED_ST_OP:     green_sel = PAT_ON;
                `FLED_ST_PREOP:  green_sel = PAT_BLINK;
                `FLED_ST_SAFEOP: green_sel = PAT_SINGLE;
                `FLED_ST_INIT:   green_sel = PAT_OFF;
                default:         green_sel = PAT_OFF;
            endcase
        end
    end

    // red pattern by fixed priority, first match wins
    always @* begin
        red_sel   = PAT_OFF;
        red_flick = 1'b0;
        if (pdi_wdog_timeout) begin
            red_sel = PAT_ON;
        end else if (app_wdog_timeout) begin
            red_sel = PAT_DOUBLE;
        end else if (al_state_valid && al_state == `FLED_ST_INIT && al_change_flag == `FLED_CHANGE_ERR) begin
            red_flick = FLICK_SEL;
        end else if (config_error) begin
            red_sel = PAT_BLINK;
        end else if (al_state_valid && al_change_flag == `FLED_CHANGE_ERR) begin
            red_sel = PAT_SINGLE;
        end else begin
            red_sel = PAT_OFF;
        end
    end

    // map a selector to the lamp level
    function lamp;
        input [4:0] sel;
        input       flk;
        input       blk;
        input       sgl;
        input       dbl;
        input       fl;
        begin
            if (flk) begin
                lamp = fl;
            end else begin
                case (sel)
                    PAT_ON:     lamp = 1'b1;
                    PAT_BLINK:  lamp = blk;
                    PAT_SINGLE: lamp = sgl;
                    PAT_DOUBLE: lamp = dbl;
                    default:    lamp = 1'b0;
                endcase
            end
        end
    endfunction

    // registered led outputs, two-lamp and bi-colour forms
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_green_q <= 1'b0;
            error_red_q    <= 1'b0;
            bicolor_pos_q  <= 1'b0;
            bicolor_neg_q  <= 1'b0;
        end else begin
            status_green_q <= lamp(green_sel, green_flick, blink_q, single_q, double_q, flick_q);
            error_red_q    <= lamp(red_sel, red_flick, blink_q, single_q, double_q, flick_q);
            // bi-colour: red wins the shared lamp when lit
            bicolor_neg_q  <= lamp(red_sel, red_flick, blink_q, single_q, double_q, flick_q);
            bicolor_pos_q  <= lamp(green_sel, green_flick, blink_q, single_q, double_q, flick_q) &
                              ~lamp(red_sel, red_flick, blink_q, single_q, double_q, flick_q);
        end
    end

    // per-port link indicators
    fled_link u_link_in (
        .clk        (clk),
        .reset_n    (reset_n),
        .tick       (tick_q),
        .flicker    (flick_q),
        .link_valid (link_in_valid),
        .activity   (link_in_activity),
        .led_q      (port_in_link_indicator)
    );

    fled_link u_link_out (
        .clk        (clk),
        .reset_n    (reset_n),
        .tick       (tick_q),
        .flicker    (flick_q),
        .link_valid (link_out_valid),
        .activity   (link_out_activity),
        .led_q      (port_out_link_indicator)
    );

endmodule

// ---- fled_top_chk.sv ----
// fled_top_chk.sv: port assertions for the indicator generator
// assumes one clk domain and reset_n active low
`timescale 1ns/10ps
`include "fled_consts.vh"

module fled_top_chk (
    input wire       clk,
    input wire       reset_n,
    input wire       link_in_valid,
    input wire       link_out_valid,
    input wire [3:0] al_state,
    input wire       al_state_valid,
    input wire       fw_download,
    input wire [7:0] al_change_flag,
    input wire       pdi_wdog_timeout,
    input wire       config_error,
    input wire       app_wdog_timeout,
    input wire       port_in_link_indicator,
    input wire       port_out_link_indicator,
    input wire       status_green_q,
    input wire       error_red_q,
    input wire       bicolor_pos_q,
    input wire       bicolor_neg_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // state reported, no download
    wire nrm = al_state_valid && !fw_download;
    // no red cause present
    wire quiet = !pdi_wdog_timeout && !config_error && !app_wdog_timeout && al_change_flag != 8'h01;

    sequence s_op;
        (nrm && al_state == `FLED_ST_OP) [*2];
    endsequence
    sequence s_init;
        (nrm && al_state == `FLED_ST_INIT) [*2];
    endsequence

    a_link_in_off: assert property (!link_in_valid |=> !port_in_link_indicator)
        else $error("in link lamp lit without link");
    a_link_out_off: assert property (!link_out_valid |=> !port_out_link_indicator)
        else $error("out link lamp lit without link");
    a_green_op: assert property (s_op |-> status_green_q)
        else $error("green dark in operational");
    a_green_init: assert property (s_init |-> !status_green_q)
        else $error("green lit in init");
    a_red_pdi: assert property (pdi_wdog_timeout [*2] |-> error_red_q)
        else $error("red dark after pdi timeout");
    a_red_quiet: assert property (quiet [*2] |-> !error_red_q)
        else $error("red lit without cause");
    a_bicolor_red: assert property (bicolor_neg_q == error_red_q)
        else $error("bicolour red drive wrong");
    a_bicolor_green: assert property (bicolor_pos_q == (status_green_q && !error_red_q))
        else $error("bicolour green drive wrong");
endmodule

bind fled_top fled_top_chk u_fled_top_chk (.*);

// ---- fled_top_tb.sv ----
// fled_top_tb.sv: self-checking bench for the indicator generator
// assumes fled_top with a short tick, lamps modelled by fled_led_mon
`timescale 1ns/10ps
`include "fled_consts.vh"

module fled_top_tb;
    reg         clk = 0, reset_n = 0, liv = 0, lia = 0, lov = 0, loa = 0;
    reg         asv = 0, dl = 0, pdi = 0, cfg = 0, app = 0;
    reg  [3:0]  st = 0;
    reg  [7:0]  fl = 0;
    wire        pin, pout, grn, red;
    wire [15:0] g_on, g_off, r_on, r_off;
    wire [7:0]  g_r, r_r, l_r;
    integer     error_cnt = 0, total_checks = 0;
    reg  [15:0] gap;
    reg  [7:0]  c0;
    reg  [7:0]  c1;

    // 100 MHz clock
    always #5 clk = ~clk;

    fled_top #(.TICK_CYCLES(10)) u_fled_top (.clk(clk), .reset_n(reset_n),
        .link_in_valid(liv), .link_in_activity(lia), .link_out_valid(lov), .link_out_activity(loa),
        .al_state(st), .al_state_valid(asv), .fw_download(dl), .al_change_flag(fl),
        .pdi_wdog_timeout(pdi), .config_error(cfg), .app_wdog_timeout(app),
        .port_in_link_indicator(pin), .port_out_link_indicator(pout), .status_green_q(grn),
        .error_red_q(red), .bicolor_pos_q(), .bicolor_neg_q());
    fled_led_mon u_fled_led_mon_g (.clk(clk), .lit(grn), .on_len(g_on), .off_len(g_off), .rises(g_r));
    fled_led_mon u_fled_led_mon_r (.clk(clk), .lit(red), .on_len(r_on), .off_len(r_off), .rises(r_r));
    fled_led_mon u_fled_led_mon_l (.clk(clk), .lit(pin), .on_len(), .off_len(), .rises(l_r));

    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask

    task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %0s expected %0d seen %0d", nm, e, g);
            end
        end
    endtask

    task rise(input r);
        integer i;
        begin
            c0 = r ? r_r : g_r;
            for (i = 0; i < 600 && (r ? r_r : g_r) === c0; i = i + 1)
                cyc(1);
        end
    endtask

    // third rise so both runs are whole phases
    task pat(input r, input [15:0] on, input [15:0] off);
        begin
            c1 = r ? r_r : g_r;
            rise(r);
            rise(r);
            rise(r);
            // a lamp that never rises would leave stale run lengths behind
            c1 = (r ? r_r : g_r) - c1;
            chk("rises", 3, {8'h00, c1});
            chk("on_len", on, r ? r_on : g_on);
            chk("off_len", off, r ? r_off : g_off);
        end
    endtask

    task set(input [3:0] s, input v, input d, input [7:0] f, input p, input c, input a);
        begin
            {st, asv, dl, fl, pdi, cfg, app} = {s, v, d, f, p, c, a};
            cyc(2);
        end
    endtask

    task steady(input r, input e);
        integer i;
        begin
            cyc(60);
            for (i = 0; i < 6; i = i + 1) begin
                chk("steady", e, r ? red : grn);
                cyc(37);
            end
        end
    endtask

    task t_link;
        begin
            liv = 1;
            cyc(40);
            chk("in_idle", 1, pin);
            chk("out_off", 0, pout);
            lov = 1;
            c0 = l_r;
            lia = 1;
            cyc(200);
            chk("out_steady", 1, pout);
            lia = 0;
            chk("flicker", 1, (l_r - c0) >= 8'h05);
            cyc(40);
            chk("in_back", 1, pin);
            chk("out_on", 1, pout);
            liv = 0;
            cyc(2);
            chk("in_gone", 0, pin);
            $display("test link done");
        end
    endtask

    task t_green;
        begin
            set(`FLED_ST_OP, 1, 0, 0, 0, 0, 0);
            steady(0, 1);
            set(`FLED_ST_INIT, 1, 0, 0, 0, 0, 0);
            steady(0, 0);
            set(`FLED_ST_PREOP, 1, 0, 0, 0, 0, 0);
            pat(0, 40, 40);
            set(`FLED_ST_SAFEOP, 1, 0, 0, 0, 0, 0);
            pat(0, 40, 200);
            set(`FLED_ST_BOOT, 1, 0, 0, 0, 0, 0);
            pat(0, 10, 10);
            set(`FLED_ST_OP, 0, 0, 0, 0, 0, 0);
            pat(0, 10, 10);
            set(`FLED_ST_OP, 1, 1, 0, 0, 0, 0);
            pat(0, 10, 10);
            $display("test green done");
        end
    endtask

    task t_red;
        begin
            set(`FLED_ST_INIT, 1, 0, `FLED_CHANGE_ERR, 0, 0, 0);
            pat(1, 10, 10);
            set(`FLED_ST_PREOP, 1, 0, `FLED_CHANGE_ERR, 0, 0, 0);
            pat(1, 40, 200);
            set(`FLED_ST_OP, 1, 0, 0, 0, 1, 0);
            pat(1, 40, 40);
            set(`FLED_ST_OP, 1, 0, 0, 0, 1, 1);
            // double flash: dark runs alternate, so judge two gaps together
            rise(1);
            rise(1);
            rise(1);
            chk("dbl_on", 40, r_on);
            gap = r_off;
            rise(1);
            chk("dbl_on2", 40, r_on);
            chk("dbl_gaps", 240, gap + r_off);
            chk("dbl_short", 40, (gap < r_off) ? gap : r_off);
            set(`FLED_ST_OP, 1, 0, `FLED_CHANGE_ERR, 1, 1, 1);
            steady(1, 1);
            set(`FLED_ST_OP, 1, 0, 0, 0, 0, 0);
            steady(1, 0);
            $display("test red done");
        end
    endtask

    task summarize;
        begin
            $display("checks %0d mismatches %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // main sequence
    initial begin
        cyc(2);
        reset_n = 1;
        cyc(1);
        t_link;
        t_green;
        t_red;
        summarize;
    end

    // watchdog, run needs about 4000 cycles, limit at 20000
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        summarize;
    end
endmodule
